/* File: src/ssa_assembly.sv */
// Status assembly framer: builds poll, strobe and change-of-state responses.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_defines.svh"
module ssa_assembly (
  input wire logic sys_clk, // System clock, 20 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire ssa_pkg::ssa_req_type req_kind, // Request kind from the master.
  input wire logic req_valid, // One-cycle request strobe.
  input wire logic cfg_addr_we, // Write strobe for the node address.
  input wire logic [5:0] cfg_addr, // Node address to configure.
  input wire logic cfg_rate_we, // Write strobe for the bit rate.
  input wire logic [1:0] cfg_rate, // Bit rate code to configure.
  input wire logic st_fault, // Fault state.
  input wire logic st_warn_intr, // Warning zone intrusion.
  input wire logic st_weak, // Weak signal.
  input wire logic st_ecc_en, // External contactor check enabled.
  input wire logic st_det_intr, // Detection zone intrusion or follow mode.
  input wire logic st_stop, // Machine stop.
  input wire logic st_run, // Machine run.
  input wire logic st_ilock, // Interlock.
  input wire logic st_wout_zone, // Warning output for the warning zone.
  input wire logic st_wout_weak, // Warning output for weak signal.
  input wire logic st_zone_set, // Detection zone set.
  input wire logic [1:0] st_multizone, // Multizone select code.
  input wire logic st_restart_mode, // Restart interlock mode.
  input wire logic st_start_mode, // Start interlock mode.
  input wire logic st_auto_mode, // Automatic start mode.
  input wire logic st_aux, // Auxiliary output.
  input wire logic [17:0] st_beams, // Bit 17 leftmost, 16..1 sectors 1..16, 0 rightmost.
  input wire logic [6:0] st_fault_code, // Displayed fault code.
  input wire logic [3:0] st_resp_code, // Response time code.
  output logic [5:0] node_addr, // Configured node address.
  output ssa_pkg::ssa_rate_type bit_rate, // Configured bit rate.
  output logic [7:0] tx_data, // Response byte.
  output logic tx_valid, // Response byte valid.
  output logic tx_last, // Last byte of the response.
  output logic expl_ack // Explicit message accepted.
);
  import ssa_pkg::*;

  ssa_state_type state_reg;
  logic [63:0] frame_reg;
  logic [3:0] len_reg;
  logic [3:0] cnt_reg;
  logic [7:0] fault_idx;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [1:0] mz_code;
  logic [7:0] frame_bytes [0:7];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      node_addr <= `SSA_ADDR_DEFAULT;
    end else if (cfg_addr_we && cfg_addr <= `SSA_ADDR_MAX) begin
      node_addr <= cfg_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_rate <= SSA_RATE_125K;
    end else if (cfg_rate_we && cfg_rate <= 2'h2) begin
      bit_rate <= ssa_rate_type'(cfg_rate);
    end
  end

  // Fault display code to index; unknown codes become zero.
  always_comb begin
    case (st_fault_code)
      7'h1E: fault_idx = 8'h01;
      7'h20: fault_idx = 8'h02;
      7'h21: fault_idx = 8'h03;
      7'h22: fault_idx = 8'h04;
      7'h23: fault_idx = 8'h05;
      7'h28: fault_idx = 8'h06;
      7'h29: fault_idx = 8'h07;
      7'h2A: fault_idx = 8'h08;
      7'h2B: fault_idx = 8'h09;
      7'h32: fault_idx = 8'h0A;
      7'h3C: fault_idx = 8'h0B;
      7'h46: fault_idx = 8'h0C;
      7'h50: fault_idx = 8'h0D;
      7'h5A: fault_idx = 8'h0E;
      default: fault_idx = `SSA_FAULT_NONE;
    endcase
  end

  always_comb begin
    mz_code = (st_multizone > `SSA_MZ_BOTH) ? `SSA_MZ_ZONE1 : st_multizone;
    byte0 = {st_fault, st_warn_intr, st_weak, st_ecc_en,
             st_det_intr, st_stop, st_run, st_ilock};
    // Multizone takes bit 4 and borrows bit 3 for its high half when both zones are set.
    byte1 = {st_wout_zone, st_wout_weak, st_zone_set, mz_code[0],
             st_restart_mode | mz_code[1], st_start_mode, st_auto_mode, st_aux};
  end

  assign frame_bytes[0] = byte0;
  assign frame_bytes[1] = byte1;
  assign frame_bytes[2] = st_beams[17:10];
  assign frame_bytes[3] = st_beams[9:2];
  assign frame_bytes[4] = fault_idx;
  assign frame_bytes[5] = {4'h0, st_resp_code};
  assign frame_bytes[6] = `SSA_RESERVED_BYTE;
  assign frame_bytes[7] = `SSA_RESERVED_BYTE;

  logic req_frame;
  assign req_frame = req_valid && (req_kind == SSA_REQ_POLL || req_kind == SSA_REQ_STROBE
                     || req_kind == SSA_REQ_COS);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= SSA_ST_IDLE;
      frame_reg <= 64'h0000_0000_0000_0000;
      len_reg <= 4'h0;
      cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        SSA_ST_IDLE: begin
          if (req_frame) begin
            frame_reg <= {frame_bytes[7], frame_bytes[6], frame_bytes[5], frame_bytes[4],
                          frame_bytes[3], frame_bytes[2], frame_bytes[1], frame_bytes[0]};
            len_reg <= (req_kind == SSA_REQ_COS) ? `SSA_COS_LEN : `SSA_RESP_LEN;
            cnt_reg <= 4'h0;
            state_reg <= SSA_ST_SEND;
          end
        end
        SSA_ST_SEND: begin
          frame_reg <= {8'h00, frame_reg[63:8]};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 == len_reg) begin
            state_reg <= SSA_ST_DONE;
          end
        end
        SSA_ST_DONE: begin
          state_reg <= SSA_ST_IDLE;
        end
        default: begin
          state_reg <= SSA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end else begin
      tx_valid <= (state_reg == SSA_ST_SEND);
      tx_data <= (state_reg == SSA_ST_SEND) ? frame_reg[7:0] : 8'h00;
      tx_last <= (state_reg == SSA_ST_SEND) && (cnt_reg + 4'h1 == len_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      expl_ack <= 1'b0;
    end else begin
      expl_ack <= req_valid && req_kind == SSA_REQ_EXPLICIT;
    end
  end

  sequence poll_req_s;
    req_valid && state_reg == SSA_ST_IDLE &&
      (req_kind == SSA_REQ_POLL || req_kind == SSA_REQ_STROBE);
  endsequence
  sequence first_byte_s;
    tx_valid && !tx_last;
  endsequence

  addr_default_a: assert property (@(posedge sys_clk)
    $past(rst) |-> node_addr == 6'h3F) else $error("node address not 63 after reset");
  rate_default_a: assert property (@(posedge sys_clk)
    $past(rst) |-> bit_rate == SSA_RATE_125K) else $error("bit rate not 125K after reset");
  explicit_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && req_kind == SSA_REQ_EXPLICIT |=> expl_ack) else $error("explicit not acked");
  poll_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##2 first_byte_s [*7] ##1 (tx_valid && tx_last))
    else $error("poll response not eight bytes");
  cos_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && state_reg == SSA_ST_IDLE && req_kind == SSA_REQ_COS
      |-> ##2 tx_valid && tx_last && tx_data == $past(byte0, 2))
    else $error("cos message not one byte equal to byte 0");
  byte0_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##2 tx_data == $past(byte0, 2)) else $error("byte 0 mismatch");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_last && !$past(tx_last) && $past(tx_valid) |-> tx_data == 8'h00)
    else $error("reserved byte 7 not zero");
  fault_map_a: assert property (@(posedge sys_clk)
    st_fault_code == 7'h5A |-> fault_idx == 8'h0E) else $error("fault 90 not index 14");
  resp_upper_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##7 tx_data == {4'h0, $past(st_resp_code, 7)})
    else $error("byte 5 not the response time code");
  byte1_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##3 tx_data[7:5] == $past({st_wout_zone, st_wout_weak, st_zone_set}, 3)
      && tx_data[2:0] == $past({st_start_mode, st_auto_mode, st_aux}, 3)
      && tx_data[4] == $past(st_multizone == `SSA_MZ_ZONE2, 3))
    else $error("byte 1 mismatch");
  beam_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##4 tx_data == $past(st_beams[17:10], 4)
      ##1 tx_data == $past(st_beams[9:2], 5))
    else $error("beam bytes mismatch");
  fault_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s ##0 st_fault_code == 7'h1E |-> ##6 tx_data == 8'h01)
    else $error("fault 30 not index 1");
  byte6_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    poll_req_s |-> ##8 tx_data == 8'h00) else $error("reserved byte 6 not zero");
  frame_gapless_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && !tx_last |=> tx_valid) else $error("gap inside a response");
endmodule
`default_nettype wire

/* File: src/ssa_defines.svh */
// Constant definitions for the scanner status assembly block.
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH
`define SSA_ADDR_DEFAULT 6'h3F
`define SSA_ADDR_MAX 6'h3F
`define SSA_RESP_LEN 4'h8
`define SSA_COS_LEN 4'h1
`define SSA_RT_BASE_MS 80
`define SSA_RT_STEP_MS 40
`define SSA_MZ_ZONE1 2'h0
`define SSA_MZ_ZONE2 2'h1
`define SSA_MZ_BOTH 2'h2
`define SSA_FAULT_NONE 8'h00
`define SSA_RESERVED_BYTE 8'h00
`endif

/* File: src/ssa_pkg.sv */
// Type definitions for the scanner status assembly block.
package ssa_pkg;
  typedef enum logic [1:0] {
    SSA_RATE_125K = 2'h0,
    SSA_RATE_250K = 2'h1,
    SSA_RATE_500K = 2'h2
  } ssa_rate_type;
  typedef enum logic [2:0] {
    SSA_REQ_NONE = 3'h0,
    SSA_REQ_POLL = 3'h1,
    SSA_REQ_STROBE = 3'h2,
    SSA_REQ_COS = 3'h3,
    SSA_REQ_EXPLICIT = 3'h4
  } ssa_req_type;
  typedef enum logic [2:0] {
    SSA_ST_IDLE = 3'h1,
    SSA_ST_SEND = 3'h2,
    SSA_ST_DONE = 3'h4
  } ssa_state_type;
endpackage

/* File: tb/ssa_master_model.sv */
// Network master model: issues requests and gathers response bytes.
`timescale 1ns/1ps
`default_nettype none
module ssa_master_model (
  input wire logic sys_clk, // System clock.
  input wire logic [7:0] tx_data, // Response byte.
  input wire logic tx_valid, // Response byte valid.
  input wire logic tx_last, // Last byte flag.
  output var ssa_pkg::ssa_req_type req_kind, // Request kind.
  output logic req_valid // Request strobe.
);
  import ssa_pkg::*;
  logic [8:0] rx_q[$];
  initial begin
    req_kind = SSA_REQ_NONE;
    req_valid = 1'b0;
  end
  // The strobe stands for exactly one edge, so a request is never taken twice.
  task automatic send(input ssa_req_type kind);
    @(negedge sys_clk);
    req_kind = kind;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    req_kind = SSA_REQ_NONE;
  endtask
  always @(posedge sys_clk) begin
    if (tx_valid) begin
      rx_q.push_back({tx_last, tx_data});
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_ssa_assembly.sv */
// Self-checking testbench for the scanner status assembly framer.
`timescale 1ns/1ps
`default_nettype none
module test_ssa_assembly;
  import ssa_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_addr_we = 1'b0;
  logic cfg_rate_we = 1'b0;
  logic [5:0] cfg_addr = 6'h00;
  logic [1:0] cfg_rate = 2'h0;
  logic [45:0] st = '0;
  logic [5:0] node_addr;
  ssa_rate_type bit_rate;
  logic [7:0] tx_data;
  logic tx_valid, tx_last, expl_ack, req_valid;
  ssa_req_type req_kind;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 32'h42b0_b436;
  int codes[14] = '{30, 32, 33, 34, 35, 40, 41, 42, 43, 50, 60, 70, 80, 90};
  ssa_req_type kinds[3] = '{SSA_REQ_POLL, SSA_REQ_STROBE, SSA_REQ_COS};
  logic [7:0] exp_q[$];
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  ssa_assembly ssa_assembly_inst (.sys_clk(sys_clk), .rst(rst), .req_kind(req_kind),
    .req_valid(req_valid), .cfg_addr_we(cfg_addr_we), .cfg_addr(cfg_addr),
    .cfg_rate_we(cfg_rate_we), .cfg_rate(cfg_rate), .st_fault(st[7]), .st_warn_intr(st[6]),
    .st_weak(st[5]), .st_ecc_en(st[4]), .st_det_intr(st[3]), .st_stop(st[2]), .st_run(st[1]),
    .st_ilock(st[0]), .st_wout_zone(st[16]), .st_wout_weak(st[15]), .st_zone_set(st[14]),
    .st_multizone(st[13:12]), .st_restart_mode(st[11]), .st_start_mode(st[10]),
    .st_auto_mode(st[9]), .st_aux(st[8]), .st_beams(st[34:17]), .st_fault_code(st[41:35]),
    .st_resp_code(st[45:42]), .node_addr(node_addr), .bit_rate(bit_rate), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .expl_ack(expl_ack));
  ssa_master_model ssa_master_model_inst (.sys_clk(sys_clk), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .req_kind(req_kind), .req_valid(req_valid));
  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_byte(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_cfg(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic frame(input ssa_req_type kind, input bit intrude);
    logic [1:0] mz;
    logic [7:0] fi;
    logic [8:0] want;
    logic [8:0] got;
    int n;
    mz = (st[13:12] == 2'h3) ? 2'h0 : st[13:12];
    fi = 8'h00;
    for (int k = 0; k < 14; k++) begin
      if (codes[k] == int'(st[41:35])) fi = 8'(k + 1);
    end
    exp_q = '{st[7:0]};
    if (kind != SSA_REQ_COS) begin
      exp_q = '{st[7:0], {st[16:14], mz[0], st[11] | mz[1], st[10:8]}, st[34:27], st[26:19],
        fi, {4'h0, st[45:42]}, 8'h00, 8'h00};
    end
    ssa_master_model_inst.rx_q.delete();
    ssa_master_model_inst.send(kind);
    // A second request in mid-frame must be dropped without a trace.
    if (intrude) ssa_master_model_inst.send(SSA_REQ_POLL);
    for (n = 0; n < 30; n++) begin
      @(negedge sys_clk);
      if (ssa_master_model_inst.rx_q.size() >= exp_q.size()) break;
    end
    if (n == 30) begin
      fail_count++;
      $display("Error frame end expected done seen timeout");
      stop_test();
    end
    repeat (4) @(negedge sys_clk);
    chk_cfg("frame length", 8'(exp_q.size()), 8'(ssa_master_model_inst.rx_q.size()));
    for (int k = 0; k < exp_q.size() && k < ssa_master_model_inst.rx_q.size(); k++) begin
      want = {k == exp_q.size() - 1, exp_q[k]};
      got = ssa_master_model_inst.rx_q[k];
      chk_byte("frame byte", want, got);
    end
  endtask
  initial begin
    int hits;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_cfg("node address", 8'h3F, {2'h0, node_addr});
    chk_cfg("bit rate", 8'h00, {6'h00, bit_rate});
    for (int k = 0; k < 4; k++) begin
      cfg_addr = 6'(k * 21);
      cfg_rate = 2'(k);
      cfg_addr_we = 1'b1;
      cfg_rate_we = 1'b1;
      @(negedge sys_clk);
      cfg_addr_we = 1'b0;
      cfg_rate_we = 1'b0;
      @(negedge sys_clk);
      chk_cfg("node address", {2'h0, cfg_addr}, {2'h0, node_addr});
      chk_cfg("bit rate", (k == 3) ? 8'h02 : 8'(k), {6'h00, bit_rate});
    end
    // A reset in mid-run must bring both settings back to their defaults.
    cfg_addr = 6'h05;
    cfg_addr_we = 1'b1;
    @(negedge sys_clk);
    cfg_addr_we = 1'b0;
    chk_cfg("node address", 8'h05, {2'h0, node_addr});
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk_cfg("node address", 8'h3F, {2'h0, node_addr});
    chk_cfg("bit rate", 8'h00, {6'h00, bit_rate});
    hits = 0;
    ssa_master_model_inst.send(SSA_REQ_EXPLICIT);
    for (int k = 0; k < 3; k++) begin
      hits += int'(expl_ack === 1'b1);
      @(negedge sys_clk);
    end
    chk_cfg("explicit ack", 8'h01, 8'(hits));
    for (int i = 0; i < 36; i++) begin
      st = 46'({$random(seed), $random(seed)});
      if (i < 32) st[41:35] = 7'(codes[i % 14]);
      st[45:42] = 4'(i);
      frame(kinds[i % 3], (i % 5 == 1) && (i % 3 != 2));
    end
    stop_test();
  end
endmodule
`default_nettype wire
